// >>> design/abd_pkg.sv
// Purpose : Shared constants for the auto-baud measurement block
// Assumes : AXI4-Lite slave, 32-bit data, 8-bit byte address
// Notes   : Offsets are byte addresses, one aligned word each
package abd_pkg;
  // ----------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  DIV_OFF     = 8'h04;
  localparam logic [7:0]  RXD_OFF     = 8'h08;
  localparam logic [7:0]  IST_OFF     = 8'h0C;
  localparam logic [7:0]  IMSK_OFF    = 8'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------
  localparam int CB_REQ  = 0;
  localparam int CB_WUE  = 1;
  localparam int CB_WIDE = 2;
  localparam int CB_HS   = 3;
  localparam int CB_OVF  = 4;
  localparam int CB_RXF  = 5;
  localparam int CB_BUSY = 6;

  // Interrupt status / mask fields
  localparam int IB_DONE = 0;
  localparam int IB_OVF  = 1;
  localparam int IRQ_W   = 2;

  // ----------------------------------------------------------
  // Measurement timing
  // ----------------------------------------------------------
  localparam int         PRESC_W     = 9;
  localparam logic [8:0] PRESC_TC_512 = 9'h1FF;
  localparam logic [8:0] PRESC_TC_128 = 9'h07F;
  localparam logic [8:0] PRESC_TC_32  = 9'h01F;
  localparam logic [15:0] CNT_START  = 16'h0001;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [2:0]  RISE_LAST  = 3'h5;
  localparam logic [15:0] DIV_RESET  = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BREAK_LOW,
    ST_BREAK_END,
    ST_START,
    ST_FIRST_RISE,
    ST_COUNT
  } meas_state_e;
endpackage : abd_pkg

// >>> design/auto_baud_detect.sv
// Purpose : Auto-baud measurement of a 55h sync character
// Assumes : rx is synchronous to aclk; aclk is the oscillator
// Notes   : Registers over AXI4-Lite; one level interrupt
//
// Behaviour
// - Request bit starts a measurement sequence
// - Receive line times the divisor counter
// - Receiver held idle during measurement
// - Sync character 55h gives five rises
// - Count starts at first rise after start
// - Fifth rise stops; count stays in divisor
// - Completion clears request, raises receive flag
// - Reading receive data clears receive flag
// - Divisor pair counts as one 16-bit counter
// - Counter runs at eighth of base rate
// - Prescale 512, 128 or 32 by settings
// - Final count is average bit time
// - Wake-on-break skips break, measures next byte
// - Counter starts from value one
// - Overflow sets flag, counting continues
// - Overflow clear only after request cleared
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module auto_baud_detect (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 rx,
  output logic                      receiver_hold,
  output logic                      irq
);
  // ----------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------
  logic        aw_hold_ff, nxt_aw_hold;
  logic [7:0]  awaddr_ff,  nxt_awaddr;
  logic        w_hold_ff,  nxt_w_hold;
  logic [31:0] wdata_ff,   nxt_wdata;
  logic [3:0]  wstrb_ff,   nxt_wstrb;
  logic        awready_ff, nxt_awready;
  logic        wready_ff,  nxt_wready;
  logic        bvalid_ff,  nxt_bvalid;
  logic [1:0]  bresp_ff,   nxt_bresp;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff,  nxt_rvalid;
  logic [31:0] rdata_ff,   nxt_rdata;
  logic [1:0]  rresp_ff,   nxt_rresp;
  logic        wr_en;
  logic        rd_en;
  logic        rd_rxd;
  logic [31:0] rd_word;
  logic        rd_hit;

  // ----------------------------------------------------------
  // Measurement and register state
  // ----------------------------------------------------------
  abd_pkg::meas_state_e state_ff, nxt_state;
  logic        req_ff,   nxt_req;
  logic        wue_ff,   nxt_wue;
  logic        wide_ff,  nxt_wide;
  logic        hs_ff,    nxt_hs;
  logic        ovf_ff,   nxt_ovf;
  logic        rxf_ff,   nxt_rxf;
  logic [15:0] div_ff,   nxt_div;
  logic [8:0]  presc_ff, nxt_presc;
  logic [2:0]  rise_ff,  nxt_rise;
  logic        rx_d_ff,  nxt_rx_d;
  logic [1:0]  ist_ff,   nxt_ist;
  logic [1:0]  imsk_ff,  nxt_imsk;
  logic        irq_ff,   nxt_irq;
  logic        hold_ff,  nxt_hold;
  logic [8:0]  presc_tc;
  logic        tick;
  logic        rise;
  logic        fall;

  // Read mux shared by the bus group
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      abd_pkg::CTRL_OFF: begin
        rd_word[abd_pkg::CB_REQ]  = req_ff;
        rd_word[abd_pkg::CB_WUE]  = wue_ff;
        rd_word[abd_pkg::CB_WIDE] = wide_ff;
        rd_word[abd_pkg::CB_HS]   = hs_ff;
        rd_word[abd_pkg::CB_OVF]  = ovf_ff;
        rd_word[abd_pkg::CB_RXF]  = rxf_ff;
        rd_word[abd_pkg::CB_BUSY] = hold_ff;
      end
      abd_pkg::DIV_OFF:  rd_word[15:0] = div_ff;
      abd_pkg::RXD_OFF:  rd_word = 32'h0000_0000;
      abd_pkg::IST_OFF:  rd_word[1:0] = ist_ff;
      abd_pkg::IMSK_OFF: rd_word[1:0] = imsk_ff;
      default:           rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------
  // Address and data are latched separately, committed together
  always_comb begin
    nxt_aw_hold = aw_hold_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    rd_rxd      = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
      wr_en       = 1'b1;
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (awaddr_ff == abd_pkg::CTRL_OFF || awaddr_ff == abd_pkg::DIV_OFF ||
                     awaddr_ff == abd_pkg::RXD_OFF  || awaddr_ff == abd_pkg::IST_OFF ||
                     awaddr_ff == abd_pkg::IMSK_OFF) ? abd_pkg::RESP_OKAY : abd_pkg::RESP_SLVERR;
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      rd_en      = 1'b1;
      rd_rxd     = (s_axi_araddr == abd_pkg::RXD_OFF);
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_word;
      nxt_rresp  = rd_hit ? abd_pkg::RESP_OKAY : abd_pkg::RESP_SLVERR;
    end
    // Ready is registered, so it is computed from the next state
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready  = !nxt_w_hold && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= abd_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= abd_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      awaddr_ff  <= nxt_awaddr;
      w_hold_ff  <= nxt_w_hold;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------
  // Measurement engine
  // ----------------------------------------------------------
  // Prescale by settings
  // Table already folds in the eighth
  always_comb begin
    unique case ({wide_ff, hs_ff})
      2'h0:    presc_tc = abd_pkg::PRESC_TC_512;
      2'h3:    presc_tc = abd_pkg::PRESC_TC_32;
      default: presc_tc = abd_pkg::PRESC_TC_128;
    endcase
  end

  assign tick = (presc_ff == presc_tc);
  assign rise = rx && !rx_d_ff;
  assign fall = !rx && rx_d_ff;

  // Sequencer, counter, flags and software writes
  always_comb begin
    nxt_state = state_ff;
    nxt_req   = req_ff;
    nxt_wue   = wue_ff;
    nxt_wide  = wide_ff;
    nxt_hs    = hs_ff;
    nxt_ovf   = ovf_ff;
    nxt_rxf   = rxf_ff;
    nxt_div   = div_ff;
    nxt_presc = presc_ff;
    nxt_rise  = rise_ff;
    nxt_ist   = ist_ff;
    nxt_imsk  = imsk_ff;
    nxt_rx_d  = rx;
    // Read of receive data clears flag
    if (rd_rxd) begin
      nxt_rxf = 1'b0;
    end
    if (wr_en) begin
      unique case (awaddr_ff)
        abd_pkg::CTRL_OFF: if (wstrb_ff[0]) begin
          nxt_req  = wdata_ff[abd_pkg::CB_REQ];
          nxt_wue  = wdata_ff[abd_pkg::CB_WUE];
          nxt_wide = wdata_ff[abd_pkg::CB_WIDE];
          nxt_hs   = wdata_ff[abd_pkg::CB_HS];
          if (!wdata_ff[abd_pkg::CB_OVF] && !req_ff) begin
            nxt_ovf = 1'b0;
          end
        end
        abd_pkg::DIV_OFF: begin
          if (wstrb_ff[0]) nxt_div[7:0]  = wdata_ff[7:0];
          if (wstrb_ff[1]) nxt_div[15:8] = wdata_ff[15:8];
        end
        abd_pkg::IST_OFF:  if (wstrb_ff[0]) nxt_ist  = ist_ff & ~wdata_ff[1:0];
        abd_pkg::IMSK_OFF: if (wstrb_ff[0]) nxt_imsk = wdata_ff[1:0];
        default: ;
      endcase
    end
    // Abort: clearing the request drops back to idle
    if (!req_ff && state_ff != abd_pkg::ST_IDLE) begin
      nxt_state = abd_pkg::ST_IDLE;
    end else begin
      unique case (state_ff)
        abd_pkg::ST_IDLE: if (req_ff) begin
          nxt_state = wue_ff ? abd_pkg::ST_BREAK_LOW : abd_pkg::ST_START;
        end
        abd_pkg::ST_BREAK_LOW: if (fall) nxt_state = abd_pkg::ST_BREAK_END;
        abd_pkg::ST_BREAK_END: if (rise) begin
          nxt_wue   = 1'b0;
          nxt_state = abd_pkg::ST_START;
        end
        abd_pkg::ST_START: if (fall) nxt_state = abd_pkg::ST_FIRST_RISE;
        abd_pkg::ST_FIRST_RISE: if (rise) begin
          nxt_div   = abd_pkg::CNT_START;
          nxt_presc = '0;
          nxt_rise  = 3'h1;
          nxt_state = abd_pkg::ST_COUNT;
        end
        abd_pkg::ST_COUNT: begin
          nxt_presc = tick ? 9'h000 : presc_ff + 9'h001;
          if (tick) begin
            nxt_div = div_ff + 16'h0001;
            if (div_ff == abd_pkg::CNT_MAX) begin
              nxt_ovf             = 1'b1;
              nxt_ist[abd_pkg::IB_OVF] = 1'b1;
            end
          end
          if (rise) begin
            nxt_rise = rise_ff + 3'h1;
            // Count left is average bit time
            if (rise_ff + 3'h1 == abd_pkg::RISE_LAST) begin
              nxt_div   = div_ff;
              nxt_req   = 1'b0;
              nxt_rxf   = 1'b1;
              nxt_ist[abd_pkg::IB_DONE] = 1'b1;
              nxt_state = abd_pkg::ST_IDLE;
            end
          end
        end
        default: nxt_state = abd_pkg::ST_IDLE;
      endcase
    end
    nxt_hold = (nxt_state != abd_pkg::ST_IDLE);
    nxt_irq  = |(nxt_ist & nxt_imsk);
  end

  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= abd_pkg::ST_IDLE;
      req_ff   <= 1'b0;
      wue_ff   <= 1'b0;
      wide_ff  <= 1'b0;
      hs_ff    <= 1'b0;
      ovf_ff   <= 1'b0;
      rxf_ff   <= 1'b0;
      div_ff   <= abd_pkg::DIV_RESET;
      presc_ff <= 9'h000;
      rise_ff  <= 3'h0;
      rx_d_ff  <= 1'b1;
      ist_ff   <= 2'h0;
      imsk_ff  <= 2'h0;
      irq_ff   <= 1'b0;
      hold_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      wue_ff   <= nxt_wue;
      wide_ff  <= nxt_wide;
      hs_ff    <= nxt_hs;
      ovf_ff   <= nxt_ovf;
      rxf_ff   <= nxt_rxf;
      div_ff   <= nxt_div;
      presc_ff <= nxt_presc;
      rise_ff  <= nxt_rise;
      rx_d_ff  <= nxt_rx_d;
      ist_ff   <= nxt_ist;
      imsk_ff  <= nxt_imsk;
      irq_ff   <= nxt_irq;
      hold_ff  <= nxt_hold;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign receiver_hold = hold_ff;
  assign irq           = irq_ff;
endmodule : auto_baud_detect

// >>> dv/abd_asserts.sv
// Purpose: Port checks for the auto-baud block
// Assumes: One clock, synchronous active-low reset
// Notes  : Bound from the test top file
`timescale 1ns/10ps
module abd_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx,
  input wire logic        receiver_hold,
  input wire logic        irq
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Writes here always offer address and data together
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer missing");
  bad_wr_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h10
    |-> ##2 s_axi_bresp == abd_pkg::RESP_SLVERR) else $error("unmapped write accepted");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  bad_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == abd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  arm_start_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == abd_pkg::CTRL_OFF && s_axi_wdata[0] && s_axi_wstrb[0]
    |-> ##[2:3] receiver_hold) else $error("request did not hold receiver");
  arm_cause_a: assert property ($rose(receiver_hold) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("receiver held without request");
  // A mask or status write commits on the edge that raises bvalid, so irq and bvalid rise together
  irq_cause_a: assert property ($rose(irq) |-> $past(receiver_hold) || s_axi_bvalid)
    else $error("interrupt without cause");

  cover property ($fell(receiver_hold));
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == abd_pkg::RESP_SLVERR);
endmodule : abd_asserts

// >>> dv/sync_tx_model.sv
// Purpose: Remote sender of the sync character
// Assumes: Bit time given in aclk cycles
// Notes  : Line idles high between frames
`timescale 1ns/10ps
module sync_tx_model (
  input wire logic aclk,
  output logic     rx
);
  initial rx = 1'h1;

  task automatic send(input int b, input logic brk);
    logic [9:0] frame;
    frame = {1'h1, 8'h55, 1'h0};
    // Optional all-zero break ahead of the byte
    if (brk) begin
      rx <= 1'h0;
      repeat (13 * b) @(posedge aclk);
      rx <= 1'h1;
      repeat (2 * b) @(posedge aclk);
    end
    for (int i = 0; i < 10; i++) begin
      rx <= frame[i];
      repeat (b) @(posedge aclk);
    end
  endtask : send
endmodule : sync_tx_model

// >>> dv/auto_baud_detect_test.sv
// Purpose: Self-checking bench of the auto-baud block
// Assumes: Bus tasks wait on handshakes, bounded
// Notes  : Bit times leave at least a quarter prescale of margin
`timescale 1ns/10ps
module auto_baud_detect_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic        awready, wready, bvalid, arready, rvalid, rx, receiver_hold, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          miscompares, total_checks;
  int          bit_tab [4] = '{400, 140, 100, 50};
  logic [15:0] cnt_tab [4] = '{16'h0007, 16'h0009, 16'h0007, 16'h000D};

  auto_baud_detect u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx(rx),
    .receiver_hold(receiver_hold), .irq(irq));
  sync_tx_model u_tx (.aclk(aclk), .rx(rx));

  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded edge wait; a hang ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      miscompares++;
      tally_and_finish;
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // Each channel is released on its own handshake, in either order
    do begin
      tick(n);
      if (awready) aw_done = 1'h1;
      if (wready) w_done = 1'h1;
      if (aw_done) awvalid <= 1'h0;
      if (w_done) wvalid <= 1'h0;
    end while (!(aw_done && w_done));
    while (!bvalid) tick(n);
    chk(32'(bresp), 32'(er));
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do tick(n); while (!arready);
    arvalid <= 1'h0;
    do tick(n); while (!rvalid);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    rready <= 1'h0;
  endtask : rd

  // Let registered flags land before looking
  task automatic chk_out(input logic got_sel, input logic e);
    repeat (2) @(posedge aclk);
    chk(32'(got_sel ? irq : receiver_hold), 32'(e));
  endtask : chk_out

  // One measurement; sel is {speed, wide}
  task automatic measure(input logic [1:0] sel, input int b, input logic brk, input logic [15:0] e,
                         input logic m);
    wr(abd_pkg::IMSK_OFF, 32'(m), abd_pkg::RESP_OKAY);
    wr(abd_pkg::CTRL_OFF, 32'({sel, brk, 1'h1}), abd_pkg::RESP_OKAY);
    chk_out(1'h0, 1'h1);
    u_tx.send(b, brk);
    chk_out(1'h0, 1'h0);
    // Raw count kept; software would subtract one itself, high byte zero here
    rd(abd_pkg::DIV_OFF, 32'(e), abd_pkg::RESP_OKAY);
    rd(abd_pkg::CTRL_OFF, 32'({2'h2, sel, 2'h0}), abd_pkg::RESP_OKAY);
    rd(abd_pkg::IST_OFF, 32'h1, abd_pkg::RESP_OKAY);
    chk_out(1'h1, m);
    wr(abd_pkg::IMSK_OFF, 32'h1, abd_pkg::RESP_OKAY);
    chk_out(1'h1, 1'h1);
    rd(abd_pkg::RXD_OFF, 32'h0, abd_pkg::RESP_OKAY);
    rd(abd_pkg::CTRL_OFF, 32'({sel, 2'h0}), abd_pkg::RESP_OKAY);
    wr(abd_pkg::IST_OFF, 32'h3, abd_pkg::RESP_OKAY);
    chk_out(1'h1, 1'h0);
  endtask : measure

  // ----------
  // Sequence
  // ----------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, abd_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, abd_pkg::RESP_SLVERR);
    wr(8'h14, 32'hFFFF, abd_pkg::RESP_SLVERR);
    wr(abd_pkg::DIV_OFF, 32'hA55A, abd_pkg::RESP_OKAY);
    rd(abd_pkg::DIV_OFF, 32'hA55A, abd_pkg::RESP_OKAY);
    // Every prescale setting, the last behind a break
    for (int i = 0; i < 4; i++) measure(2'(i), bit_tab[i], i == 3, cnt_tab[i], i[0]);
    wr(abd_pkg::CTRL_OFF, 32'h1, abd_pkg::RESP_OKAY);
    chk_out(1'h0, 1'h1);
    wr(abd_pkg::CTRL_OFF, 32'h0, abd_pkg::RESP_OKAY);
    chk_out(1'h0, 1'h0);
    rd(abd_pkg::CTRL_OFF, 32'h0, abd_pkg::RESP_OKAY);
    tally_and_finish;
  end
endmodule : auto_baud_detect_test

bind auto_baud_detect abd_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rx(rx), .receiver_hold(receiver_hold), .irq(irq));
